// ===== verilog/flow_core_pkg.sv
// shared constants and types for the program-flow core
`default_nettype none
package flow_core_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STACK_DEPTH = 31;
    localparam int OPC_W = 16;
    localparam logic [SP_W-1:0] SP_TOP = 5'h1F;
    localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
    localparam logic [SP_W-1:0] SP_ONE = 5'h01;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [OPC_W-1:0] OPC_IDLE = 16'h0000;
    // stack pointer/status register fields
    localparam int FULL_BIT = 7;
    localparam int UNDER_BIT = 6;
    // configuration register fields
    localparam int CFG_SERR_BIT = 0;
    localparam logic CFG_SERR_RESET = 1'b1;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_STKSTAT = 8'h00;
    localparam logic [7:0] ADDR_TOP_UPPER = 8'h04;
    localparam logic [7:0] ADDR_TOP_HIGH = 8'h08;
    localparam logic [7:0] ADDR_TOP_LOW = 8'h0C;
    localparam logic [7:0] ADDR_PC_LOW = 8'h10;
    localparam logic [7:0] ADDR_PC_HIGH_HOLD = 8'h14;
    localparam logic [7:0] ADDR_PC_UPPER_HOLD = 8'h18;
    localparam logic [7:0] ADDR_TBL_PTR = 8'h1C;
    localparam logic [7:0] ADDR_TBL_LATCH = 8'h20;
    localparam logic [7:0] ADDR_CONFIG = 8'h24;
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } phase_e;
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_CALL = 4'b0001,
        OP_CALL_FAST = 4'b0010,
        OP_RETURN = 4'b0011,
        OP_RETURN_FAST = 4'b0100,
        OP_RETURN_FROM_INTERRUPT = 4'b0101,
        OP_RETURN_FROM_INTERRUPT_FAST = 4'b0110,
        OP_VECTOR = 4'b0111,
        OP_PUSH = 4'b1000,
        OP_POP = 4'b1001,
        OP_JUMP = 4'b1010,
        OP_ADD_W_PCL = 4'b1011,
        OP_TABLE_READ = 4'b1100
    } flow_op_e;
endpackage : flow_core_pkg
`default_nettype wire

// ===== verilog/stack_mem_if.sv
// carrier between the core and its return-stack memory
`default_nettype none
interface stack_mem_if;
    import flow_core_pkg::*;
    logic wrEn;
    logic [SP_W-1:0] wrIdx;
    logic [PC_W-1:0] wrData;
    logic [SP_W-1:0] rdIdx;
    logic [PC_W-1:0] rdData;
    modport core (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
    modport mem (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface : stack_mem_if
`default_nettype wire

// ===== verilog/return_stack_mem.sv
// 31 x 21 return stack storage, index 0 has no storage
`default_nettype none
module return_stack_mem
    import flow_core_pkg::*;
(
    // clock
    input wire logic core_clk,
    // access port
    stack_mem_if.mem port
);
    logic [PC_W-1:0] cells [1:STACK_DEPTH];
    logic [PC_W-1:0] rdData_r;

    assign port.rdData = rdData_r;

    always_ff @(posedge core_clk) begin
        if (port.wrEn && port.wrIdx != SP_EMPTY) begin
            cells[port.wrIdx] <= port.wrData;
        end
        // index 0 reads as zero so an empty stack returns to the reset vector
        if (port.rdIdx == SP_EMPTY) begin
            rdData_r <= PC_RESET;
        end else if (port.wrEn && port.wrIdx == port.rdIdx) begin
            rdData_r <= port.wrData;
        end else begin
            rdData_r <= cells[port.rdIdx];
        end
    end
endmodule : return_stack_mem
`default_nettype wire

// ===== verilog/flow_core.sv
// return stack, shadow registers, pc, fetch pipeline and register slave
//
// Added by the designer: the Wishbone slave port and the register addresses.
`default_nettype none
module flow_core
    import flow_core_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sysRst_n,
    // wishbone register slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // program memory fetch and table read
    output logic [PC_W-1:0] progAddr,
    input wire logic [OPC_W-1:0] progData,
    output logic [PC_W-1:0] tableAddr,
    input wire logic [7:0] tableData,
    // decoded flow operation of the executing instruction
    input wire logic [3:0] flowOp,
    input wire logic [PC_W-1:0] flowTarget,
    // live core registers and shadow restore
    input wire logic [7:0] statusIn,
    input wire logic [7:0] workingIn,
    input wire logic [3:0] bankIn,
    output logic shadowRestore,
    output logic [7:0] shadowStatus,
    output logic [7:0] shadowWorking,
    output logic [3:0] shadowBank,
    // pipeline
    output logic [OPC_W-1:0] fetchedOpcode,
    output logic opcodeValid,
    output logic [3:0] phaseOneHot,
    output logic operandRead,
    output logic resultWrite,
    // stack error device reset request
    output logic stackErrReset
);
    stack_mem_if stk ();

    return_stack_mem u_mem (
        .core_clk(core_clk),
        .port(stk.mem)
    );

    phase_e phase_r, phase_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [PC_W-1:0] fetchAddr_r, fetchAddr_nxt;
    logic [OPC_W-1:0] opcode_r, opcode_nxt;
    logic opValid_r, opValid_nxt;
    logic flush_r, flush_nxt;
    logic [3:0] phOh_r, phOh_nxt;
    logic opRd_r, opRd_nxt;
    logic resWr_r, resWr_nxt;
    logic [SP_W-1:0] sp_r, sp_nxt;
    logic full_r, full_nxt;
    logic under_r, under_nxt;
    logic serrEn_r, serrEn_nxt;
    logic errRst_r, errRst_nxt;
    logic [7:0] hiHold_r, hiHold_nxt;
    logic [4:0] upHold_r, upHold_nxt;
    logic [PC_W-1:0] table_byte_pointer_r, table_byte_pointer_nxt;
    logic [7:0] tblLatch_r, tblLatch_nxt;
    logic [7:0] shStat_r, shStat_nxt;
    logic [7:0] shWork_r, shWork_nxt;
    logic [3:0] shBank_r, shBank_nxt;
    logic restore_r, restore_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic memWe;
    logic [SP_W-1:0] memIdx;
    logic [PC_W-1:0] memData;

    logic exec;
    logic wbWr;
    logic wbRd;
    logic doPush;
    logic doPop;
    logic pushFull;
    logic popEmpty;
    logic [7:0] pclSum;
    flow_op_e op;

    assign op = flow_op_e'(flowOp);
    assign exec = (phase_r == PH_FOUR);
    assign wbRd = cyc_i && stb_i && !we_i && !ack_r;
    assign wbWr = cyc_i && stb_i && we_i && ack_r;
    assign doPush = exec && (op == OP_CALL || op == OP_CALL_FAST || op == OP_VECTOR
                             || op == OP_PUSH);
    assign doPop = exec && (op == OP_RETURN || op == OP_RETURN_FAST || op == OP_RETURN_FROM_INTERRUPT
                            || op == OP_RETURN_FROM_INTERRUPT_FAST || op == OP_POP);
    assign pushFull = (sp_r == SP_TOP);
    assign popEmpty = (sp_r == SP_EMPTY);
    assign pclSum = fetchAddr_r[7:0] + workingIn;

    assign stk.wrEn = memWe;
    assign stk.wrIdx = memIdx;
    assign stk.wrData = memData;
    assign stk.rdIdx = sp_r;

    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign progAddr = fetchAddr_r;
    assign tableAddr = table_byte_pointer_r;
    assign shadowRestore = restore_r;
    assign shadowStatus = shStat_r;
    assign shadowWorking = shWork_r;
    assign shadowBank = shBank_r;
    assign fetchedOpcode = opcode_r;
    assign opcodeValid = opValid_r;
    assign phaseOneHot = phOh_r;
    assign operandRead = opRd_r;
    assign resultWrite = resWr_r;
    assign stackErrReset = errRst_r;

    // phase sequencer and fetch pipeline
    always_comb begin
        phase_nxt = phase_r;
        pc_nxt = pc_r;
        fetchAddr_nxt = fetchAddr_r;
        opcode_nxt = opcode_r;
        opValid_nxt = opValid_r;
        flush_nxt = flush_r;
        unique case (phase_r)
            PH_ONE: begin
                phase_nxt = PH_TWO;
                fetchAddr_nxt = pc_r;
                pc_nxt = pc_r + PC_STEP;
            end
            PH_TWO: begin
                phase_nxt = PH_THREE;
            end
            PH_THREE: begin
                phase_nxt = PH_FOUR;
            end
            PH_FOUR: begin
                phase_nxt = PH_ONE;
                // next word is latched while the current one finishes executing
                opcode_nxt = progData;
                opValid_nxt = 1'b1;
                flush_nxt = 1'b0;
            end
        endcase
        // a pc write during execute turns the word just fetched into an idle slot
        if (exec) begin
            unique case (op)
                OP_CALL, OP_CALL_FAST, OP_VECTOR, OP_JUMP: begin
                    pc_nxt = flowTarget;
                    flush_nxt = 1'b1;
                end
                OP_RETURN, OP_RETURN_FAST, OP_RETURN_FROM_INTERRUPT, OP_RETURN_FROM_INTERRUPT_FAST: begin
                    pc_nxt = stk.rdData;
                    flush_nxt = 1'b1;
                end
                OP_ADD_W_PCL: begin
                    pc_nxt = {upHold_r, hiHold_r, pclSum[7:1], 1'b0};
                    flush_nxt = 1'b1;
                end
                default: begin
                end
            endcase
            if (flush_nxt) begin
                opcode_nxt = OPC_IDLE;
                opValid_nxt = 1'b0;
                // flushed here already; a pending flush would also drop the target word
                flush_nxt = 1'b0;
            end
        end
        if (wbWr && adr_i == ADDR_PC_LOW && sel_i[0]) begin
            pc_nxt = {upHold_r, hiHold_r, dat_i[7:1], 1'b0};
            flush_nxt = 1'b1;
        end
        if (flush_r && phase_r == PH_FOUR) begin
            opcode_nxt = OPC_IDLE;
            opValid_nxt = 1'b0;
        end
        if (errRst_r || !sysRst_n) begin
            phase_nxt = PH_ONE;
            pc_nxt = PC_RESET;
            fetchAddr_nxt = PC_RESET;
            opcode_nxt = OPC_IDLE;
            opValid_nxt = 1'b0;
            flush_nxt = 1'b0;
        end
    end

    // phase strobes for the datapath
    always_comb begin
        phOh_nxt = 4'h0;
        phOh_nxt[phase_nxt] = 1'b1;
        opRd_nxt = (phase_nxt == PH_TWO);
        resWr_nxt = (phase_nxt == PH_FOUR);
    end

    // return stack, flags and error reset
    always_comb begin
        sp_nxt = sp_r;
        full_nxt = full_r;
        under_nxt = under_r;
        errRst_nxt = 1'b0;
        memWe = 1'b0;
        memIdx = sp_r;
        memData = fetchAddr_r;
        if (wbWr && adr_i == ADDR_STKSTAT && sel_i[0]) begin
            sp_nxt = dat_i[SP_W-1:0];
            // flags only clear by software; writing one leaves them
            full_nxt = full_r & dat_i[FULL_BIT];
            under_nxt = under_r & dat_i[UNDER_BIT];
        end
        if (wbWr && sel_i[0] && sp_r != SP_EMPTY
            && (adr_i == ADDR_TOP_UPPER || adr_i == ADDR_TOP_HIGH
                || adr_i == ADDR_TOP_LOW)) begin
            memWe = 1'b1;
            memData = stk.rdData;
            if (adr_i == ADDR_TOP_UPPER) begin
                memData[20:16] = dat_i[4:0];
            end else if (adr_i == ADDR_TOP_HIGH) begin
                memData[15:8] = dat_i[7:0];
            end else begin
                memData[7:0] = dat_i[7:0];
            end
        end
        if (doPush) begin
            if (pushFull) begin
                full_nxt = 1'b1;
                errRst_nxt = serrEn_r;
            end else begin
                sp_nxt = sp_r + SP_ONE;
                memWe = 1'b1;
                memIdx = sp_r + SP_ONE;
                memData = fetchAddr_r;
                if (sp_r + SP_ONE == SP_TOP) begin
                    full_nxt = 1'b1;
                    errRst_nxt = serrEn_r;
                end
            end
        end
        if (doPop) begin
            if (popEmpty) begin
                under_nxt = 1'b1;
                errRst_nxt = serrEn_r;
            end else begin
                sp_nxt = sp_r - SP_ONE;
            end
        end
        // the flags survive the stack-error and system resets
        if (errRst_r || !sysRst_n) begin
            sp_nxt = SP_EMPTY;
            errRst_nxt = 1'b0;
        end
    end

    // holding registers, table read, shadow registers, configuration
    always_comb begin
        hiHold_nxt = hiHold_r;
        upHold_nxt = upHold_r;
        table_byte_pointer_nxt = table_byte_pointer_r;
        tblLatch_nxt = tblLatch_r;
        shStat_nxt = shStat_r;
        shWork_nxt = shWork_r;
        shBank_nxt = shBank_r;
        restore_nxt = 1'b0;
        serrEn_nxt = serrEn_r;
        if (wbRd && adr_i == ADDR_PC_LOW) begin
            hiHold_nxt = fetchAddr_r[15:8];
            upHold_nxt = fetchAddr_r[20:16];
        end
        if (wbWr && adr_i == ADDR_PC_HIGH_HOLD && sel_i[0]) begin
            hiHold_nxt = dat_i[7:0];
        end
        if (wbWr && adr_i == ADDR_PC_UPPER_HOLD && sel_i[0]) begin
            upHold_nxt = dat_i[4:0];
        end
        if (wbWr && adr_i == ADDR_TBL_PTR) begin
            if (sel_i[0]) table_byte_pointer_nxt[7:0] = dat_i[7:0];
            if (sel_i[1]) table_byte_pointer_nxt[15:8] = dat_i[15:8];
            if (sel_i[2]) table_byte_pointer_nxt[20:16] = dat_i[20:16];
        end
        if (wbWr && adr_i == ADDR_CONFIG && sel_i[0]) begin
            serrEn_nxt = dat_i[CFG_SERR_BIT];
        end
        if (exec && op == OP_TABLE_READ) begin
            tblLatch_nxt = tableData;
        end
        // any later vector simply overwrites the single level
        if (exec && (op == OP_VECTOR || op == OP_CALL_FAST)) begin
            shStat_nxt = statusIn;
            shWork_nxt = workingIn;
            shBank_nxt = bankIn;
        end
        if (exec && (op == OP_RETURN_FROM_INTERRUPT_FAST || op == OP_RETURN_FAST)) begin
            restore_nxt = 1'b1;
        end
    end

    // bus slave: ack one cycle after the request, then drop
    always_comb begin
        ack_nxt = cyc_i && stb_i && !ack_r;
        dat_nxt = dat_r;
        if (wbRd) begin
            dat_nxt = 32'h0000_0000;
            unique case (adr_i)
                ADDR_STKSTAT: begin
                    dat_nxt[FULL_BIT] = full_r;
                    dat_nxt[UNDER_BIT] = under_r;
                    dat_nxt[SP_W-1:0] = sp_r;
                end
                ADDR_TOP_UPPER: dat_nxt[4:0] = stk.rdData[20:16];
                ADDR_TOP_HIGH: dat_nxt[7:0] = stk.rdData[15:8];
                ADDR_TOP_LOW: dat_nxt[7:0] = stk.rdData[7:0];
                ADDR_PC_LOW: dat_nxt[7:0] = fetchAddr_r[7:0];
                ADDR_PC_HIGH_HOLD: dat_nxt[7:0] = hiHold_r;
                ADDR_PC_UPPER_HOLD: dat_nxt[4:0] = upHold_r;
                ADDR_TBL_PTR: dat_nxt[PC_W-1:0] = table_byte_pointer_r;
                ADDR_TBL_LATCH: dat_nxt[7:0] = tblLatch_r;
                ADDR_CONFIG: dat_nxt[CFG_SERR_BIT] = serrEn_r;
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_r <= PH_ONE;
            pc_r <= PC_RESET;
            fetchAddr_r <= PC_RESET;
            opcode_r <= OPC_IDLE;
            opValid_r <= 1'b0;
            flush_r <= 1'b0;
            phOh_r <= 4'h1;
            opRd_r <= 1'b0;
            resWr_r <= 1'b0;
            sp_r <= SP_EMPTY;
            full_r <= 1'b0;
            under_r <= 1'b0;
            serrEn_r <= CFG_SERR_RESET;
            errRst_r <= 1'b0;
            hiHold_r <= 8'h00;
            upHold_r <= 5'h00;
            table_byte_pointer_r <= PC_RESET;
            tblLatch_r <= 8'h00;
            shStat_r <= 8'h00;
            shWork_r <= 8'h00;
            shBank_r <= 4'h0;
            restore_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            phase_r <= phase_nxt;
            pc_r <= pc_nxt;
            fetchAddr_r <= fetchAddr_nxt;
            opcode_r <= opcode_nxt;
            opValid_r <= opValid_nxt;
            flush_r <= flush_nxt;
            phOh_r <= phOh_nxt;
            opRd_r <= opRd_nxt;
            resWr_r <= resWr_nxt;
            sp_r <= sp_nxt;
            full_r <= full_nxt;
            under_r <= under_nxt;
            serrEn_r <= serrEn_nxt;
            errRst_r <= errRst_nxt;
            hiHold_r <= hiHold_nxt;
            upHold_r <= upHold_nxt;
            table_byte_pointer_r <= table_byte_pointer_nxt;
            tblLatch_r <= tblLatch_nxt;
            shStat_r <= shStat_nxt;
            shWork_r <= shWork_nxt;
            shBank_r <= shBank_nxt;
            restore_r <= restore_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end
endmodule : flow_core
`default_nettype wire

// ===== dv/prog_mem_model.sv
// program memory stand-in answering word fetches and table byte reads
`default_nettype none
module prog_mem_model
    import flow_core_pkg::*;
(
    // instruction fetch
    input wire logic [PC_W-1:0] progAddr,
    output logic [OPC_W-1:0] progData,
    // table read
    input wire logic [PC_W-1:0] tableAddr,
    output logic [7:0] tableData
);
    timeunit 1ns;
    timeprecision 1ns;
    // patterns follow the address so a stale or shifted fetch shows up as a wrong word
    always_comb progData = progAddr[16:1] ^ 16'hC3A5;
    always_comb tableData = tableAddr[7:0] ^ 8'hA5;
endmodule : prog_mem_model
`default_nettype wire

// ===== dv/flow_core_checker.sv
// port assertions for the program-flow core
`default_nettype none
module flow_core_checker
    import flow_core_pkg::*;
(
    // clock and resets
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sysRst_n,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // fetch and flow
    input wire logic [PC_W-1:0] progAddr,
    input wire logic [OPC_W-1:0] progData,
    input wire logic [3:0] flowOp,
    input wire logic [7:0] statusIn,
    input wire logic [7:0] workingIn,
    input wire logic [3:0] bankIn,
    // results
    input wire logic shadowRestore,
    input wire logic [7:0] shadowStatus,
    input wire logic [7:0] shadowWorking,
    input wire logic [3:0] shadowBank,
    input wire logic [OPC_W-1:0] fetchedOpcode,
    input wire logic opcodeValid,
    input wire logic [3:0] phaseOneHot,
    input wire logic operandRead,
    input wire logic resultWrite,
    input wire logic stackErrReset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // an op is taken at the edge that closes phase four
    sequence s_exec(logic [3:0] op);
        phaseOneHot[3] && sysRst_n && flowOp == op;
    endsequence
    sequence s_ack_once;
        ack_o ##1 !ack_o;
    endsequence
    property p_ack_one;
        (cyc_i && stb_i && !ack_o) |=> s_ack_once;
    endproperty
    property p_phase_turn;
        (sysRst_n && !stackErrReset) |=>
            phaseOneHot == {$past(phaseOneHot[2:0]), $past(phaseOneHot[3])};
    endproperty
    property p_strobes;
        operandRead == phaseOneHot[1] && resultWrite == phaseOneHot[3];
    endproperty
    property p_addr_hold;
        (phaseOneHot[1] && sysRst_n && !cyc_i) |=> $stable(progAddr);
    endproperty
    property p_err_reset;
        stackErrReset |=> progAddr == PC_RESET && !opcodeValid && phaseOneHot == 4'h1;
    endproperty
    property p_sys_reset;
        !sysRst_n |=> progAddr == PC_RESET && phaseOneHot == 4'h1;
    endproperty
    property p_vec_shadow;
        s_exec(OP_VECTOR) |=> shadowStatus == $past(statusIn)
            && shadowWorking == $past(workingIn) && shadowBank == $past(bankIn);
    endproperty
    property p_flush;
        s_exec(OP_JUMP) |=> !opcodeValid && fetchedOpcode == OPC_IDLE;
    endproperty
    property p_latch;
        s_exec(OP_NONE) ##0 !cyc_i |=> opcodeValid && fetchedOpcode == $past(progData);
    endproperty
    property p_fast_restore;
        s_exec(OP_RETURN_FAST) |-> ##[1:2] shadowRestore;
    endproperty
    property p_plain_keep;
        s_exec(OP_RETURN_FROM_INTERRUPT) |=> !shadowRestore ##1 !shadowRestore;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("bus acknowledge is not one pulse");
    a_phase_turn: assert property (p_phase_turn)
        else $error("phase did not rotate");
    a_strobes: assert property (p_strobes)
        else $error("operand or result strobe off phase");
    a_addr_hold: assert property (p_addr_hold)
        else $error("fetch address moved outside phase one");
    a_err_reset: assert property (p_err_reset)
        else $error("stack error reset not applied");
    a_sys_reset: assert property (p_sys_reset)
        else $error("device reset not applied");
    a_vec_shadow: assert property (p_vec_shadow)
        else $error("shadow not captured on vector");
    a_flush: assert property (p_flush)
        else $error("fetched word not flushed on jump");
    a_latch: assert property (p_latch)
        else $error("fetched word not latched");
    a_fast_restore: assert property (p_fast_restore)
        else $error("fast return gave no restore");
    a_plain_keep: assert property (p_plain_keep)
        else $error("plain return restored the shadow");
endmodule : flow_core_checker
bind flow_core flow_core_checker u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .sysRst_n(sysRst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .progAddr(progAddr), .progData(progData), .flowOp(flowOp),
    .statusIn(statusIn), .workingIn(workingIn), .bankIn(bankIn),
    .shadowRestore(shadowRestore), .shadowStatus(shadowStatus),
    .shadowWorking(shadowWorking), .shadowBank(shadowBank), .fetchedOpcode(fetchedOpcode),
    .opcodeValid(opcodeValid), .phaseOneHot(phaseOneHot), .operandRead(operandRead),
    .resultWrite(resultWrite), .stackErrReset(stackErrReset)
);
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the program-flow core
`default_nettype none
module tb_top
    import flow_core_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rst_n = 1'b0, sysRst_n = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00, statusIn = 8'h00, workingIn = 8'h00;
    logic [3:0] sel_i = 4'h0, bankIn = 4'h0, flowOp = OP_NONE;
    logic [31:0] dat_i = 32'h0, dat_o, rdData;
    logic [PC_W-1:0] flowTarget = PC_RESET, progAddr, tableAddr;
    logic [OPC_W-1:0] progData, fetchedOpcode;
    logic [7:0] tableData, shadowStatus, shadowWorking;
    logic [3:0] shadowBank, phaseOneHot;
    logic ack_o, shadowRestore, opcodeValid, operandRead, resultWrite, stackErrReset;
    int mismatches = 0, n_compared = 0, errPulses = 0, restores = 0;

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (stackErrReset === 1'b1) errPulses++;
        if (shadowRestore === 1'b1) restores++;
    end

    flow_core dut (
        .core_clk(core_clk), .rst_n(rst_n), .sysRst_n(sysRst_n), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .progAddr(progAddr), .progData(progData), .tableAddr(tableAddr), .tableData(tableData),
        .flowOp(flowOp), .flowTarget(flowTarget), .statusIn(statusIn), .workingIn(workingIn),
        .bankIn(bankIn), .shadowRestore(shadowRestore), .shadowStatus(shadowStatus),
        .shadowWorking(shadowWorking), .shadowBank(shadowBank), .fetchedOpcode(fetchedOpcode),
        .opcodeValid(opcodeValid), .phaseOneHot(phaseOneHot), .operandRead(operandRead),
        .resultWrite(resultWrite), .stackErrReset(stackErrReset)
    );
    prog_mem_model mem (.progAddr(progAddr), .progData(progData), .tableAddr(tableAddr),
        .tableData(tableData));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one classic cycle; only the watchdog ends the wait for ack
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= adr;
        dat_i <= dat;
        sel_i <= sel;
        do @(posedge core_clk); while (ack_o !== 1'b1);
        rdData = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rdChk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0, 4'hF);
        check(what, exp, rdData);
    endtask : rdChk

    // the op is held through phase four only, as the decoder would present it
    task automatic issue(input logic [3:0] op, input logic [PC_W-1:0] tgt);
        do @(posedge core_clk); while (phaseOneHot !== 4'h4);
        flowOp <= op;
        flowTarget <= tgt;
        @(posedge core_clk);
        flowOp <= OP_NONE;
    endtask : issue

    task automatic fetchAt(input logic [PC_W-1:0] exp);
        do @(posedge core_clk); while (phaseOneHot !== 4'h4);
        check("fetch address", {11'h000, exp}, {11'h000, progAddr});
    endtask : fetchAt

    task automatic shadowIs(input logic [19:0] exp);
        @(posedge core_clk);
        check("shadow copy", {12'h000, exp}, {12'h000, shadowStatus, shadowWorking, shadowBank});
    endtask : shadowIs

    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdChk("status", ADDR_STKSTAT, 32'h00);
        rdChk("config", ADDR_CONFIG, 32'h01);
        rdChk("unmapped", 8'h30, 32'h00);
        bus(1'b1, ADDR_CONFIG, 32'h0, 4'h1);
        issue(OP_JUMP, 21'h000100);
        fetchAt(21'h000100);
        // the 32nd push meets a full stack and must leave entry 31 alone
        repeat (32) issue(OP_PUSH, PC_RESET);
        rdChk("status", ADDR_STKSTAT, 32'h9F);
        rdChk("top low", ADDR_TOP_LOW, 32'h3E);
        rdChk("top high", ADDR_TOP_HIGH, 32'h01);
        rdChk("top upper", ADDR_TOP_UPPER, 32'h00);
        issue(OP_POP, PC_RESET);
        rdChk("status", ADDR_STKSTAT, 32'h9E);
        rdChk("top low", ADDR_TOP_LOW, 32'h3C);
        bus(1'b1, ADDR_TOP_LOW, 32'h57, 4'h1);
        rdChk("top low", ADDR_TOP_LOW, 32'h57);
        sysRst_n <= 1'b0;
        @(posedge core_clk);
        sysRst_n <= 1'b1;
        rdChk("status", ADDR_STKSTAT, 32'h80);
        issue(OP_RETURN, PC_RESET);
        fetchAt(PC_RESET);
        rdChk("status", ADDR_STKSTAT, 32'hC0);
        check("error resets", 32'h0, errPulses);
        bus(1'b1, ADDR_STKSTAT, 32'h3F, 4'h1);
        rdChk("status", ADDR_STKSTAT, 32'h1F);
        bus(1'b1, ADDR_CONFIG, 32'h1, 4'h1);
        bus(1'b1, ADDR_STKSTAT, 32'h00, 4'h1);
        issue(OP_POP, PC_RESET);
        rdChk("status", ADDR_STKSTAT, 32'h40);
        bus(1'b1, ADDR_STKSTAT, 32'h1E, 4'h1);
        issue(OP_PUSH, PC_RESET);
        // the pointer clears at the edge that ends the error reset pulse
        @(posedge core_clk);
        rdChk("status", ADDR_STKSTAT, 32'h80);
        check("error resets", 32'h2, errPulses);
        statusIn <= 8'h11;
        workingIn <= 8'h22;
        bankIn <= 4'h3;
        issue(OP_VECTOR, 21'h000008);
        shadowIs(20'h11223);
        statusIn <= 8'h44;
        workingIn <= 8'h55;
        bankIn <= 4'h6;
        issue(OP_VECTOR, 21'h000018);
        shadowIs(20'h44556);
        issue(OP_RETURN_FROM_INTERRUPT, PC_RESET);
        issue(OP_RETURN_FROM_INTERRUPT_FAST, PC_RESET);
        repeat (2) @(posedge core_clk);
        check("restore pulses", 32'h1, restores);
        statusIn <= 8'h77;
        workingIn <= 8'h88;
        bankIn <= 4'h9;
        issue(OP_CALL_FAST, 21'h000300);
        shadowIs(20'h77889);
        issue(OP_RETURN_FAST, PC_RESET);
        repeat (2) @(posedge core_clk);
        check("restore pulses", 32'h2, restores);
        bus(1'b1, ADDR_PC_HIGH_HOLD, 32'h12, 4'h1);
        bus(1'b1, ADDR_PC_UPPER_HOLD, 32'h01, 4'h1);
        issue(OP_JUMP, 21'h000200);
        fetchAt(21'h000200);
        workingIn <= 8'h08;
        issue(OP_ADD_W_PCL, PC_RESET);
        fetchAt(21'h01120A);
        bus(1'b1, ADDR_TBL_PTR, 32'h345, 4'h7);
        issue(OP_TABLE_READ, PC_RESET);
        rdChk("table latch", ADDR_TBL_LATCH, 32'hE0);
        report_and_stop();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        #(100 * 4000);
        mismatches++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
